// file: iss_pkg.sv
// shared constants, timing figures and state types for the address-select link
// Behaviour
// - sample select pin after reset, latch as address
// - select low answers 0x20/0x21, high 0x22/0x23
// - standard 7-bit slave, address 001000 plus latched bit
// - eighth bit: 0 write, 1 read
// - host holds bus high, select steady during startup
// - host waits 10 ms before first transfer
// - low select raised after 10 ms, before transfer
// - low select: warm reset only 1 ms after transfer
// - select may be strapped when no warm reset
// - host idles bus high before warm reset
// - warm reset holds select low 10 us minimum
// - address choice settled within 1 ms of fall
// - host waits 10 ms after fall before transfer
// - select low pulse restarts slave, re-samples address
// - device sleeps on its own, no external control
// - sleeping device wakes on its own address
package iss_pkg;
    localparam int unsigned SYS_PERIOD_NS  = 50;
    localparam int unsigned LINK_PERIOD_NS = 12;
    localparam int unsigned T_STARTUP_NS   = 10_000_000;
    localparam int unsigned T_HRST_NS      = 1_000_000;
    localparam int unsigned T_RSTLOW_NS    = 10_000;
    localparam int unsigned T_QUARTER_NS   = 2_500;
    localparam int unsigned T_DREADY_NS    = 9_500_000;
    localparam int unsigned T_DSAMPLE_NS   = 2_000_000;
    localparam int unsigned T_DSLEEP_NS    = 100_000;

    function automatic int unsigned cyc_up(input int unsigned t, input int unsigned p);
        int unsigned c;
        c = (t + p - 1) / p;
        return (c == 0) ? 1 : c;
    endfunction : cyc_up

    localparam int unsigned H_STARTUP_CYC = cyc_up(T_STARTUP_NS, SYS_PERIOD_NS);
    localparam int unsigned H_HRST_CYC    = cyc_up(T_HRST_NS, SYS_PERIOD_NS);
    localparam int unsigned H_RSTLOW_CYC  = cyc_up(T_RSTLOW_NS, SYS_PERIOD_NS);
    localparam int unsigned H_QUARTER_CYC = cyc_up(T_QUARTER_NS, SYS_PERIOD_NS);
    localparam int unsigned D_READY_CYC   = cyc_up(T_DREADY_NS, LINK_PERIOD_NS);
    localparam int unsigned D_SAMPLE_CYC  = cyc_up(T_DSAMPLE_NS, LINK_PERIOD_NS);
    localparam int unsigned D_SLEEP_CYC   = cyc_up(T_DSLEEP_NS, LINK_PERIOD_NS);

    localparam logic [5:0] ADDR_HI  = 6'h08;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    typedef enum logic [2:0] {
        DS_BOOT, DS_IDLE, DS_ADDR, DS_AACK, DS_WR, DS_WACK, DS_RD, DS_RACK
    } iss_dst_t;

    typedef enum logic [2:0] {
        HS_CAPT, HS_BOOT, HS_IDLE, HS_START, HS_BIT, HS_STOP
    } iss_hst_t;
endpackage : iss_pkg

// file: iss_link_if.sv
// two-wire bus plus select pin joining host and device
interface iss_link_if;
    logic h_scl_o;
    logic h_scl_oe;
    logic h_sda_o;
    logic h_sda_oe;
    logic h_sel_o;
    logic h_sel_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic scl;
    logic sda;
    logic sel;

    // pull-ups: a line reads high unless someone drives it low
    assign scl = !(h_scl_oe && !h_scl_o);
    assign sda = !((h_sda_oe && !h_sda_o) || (d_sda_oe && !d_sda_o));
    assign sel = h_sel_oe ? h_sel_o : 1'b1;

    modport host (output h_scl_o, h_scl_oe, h_sda_o, h_sda_oe, h_sel_o, h_sel_oe,
                  input scl, sda, sel);
    modport dev (output d_sda_o, d_sda_oe, input scl, sda, sel);
endinterface : iss_link_if

// file: iss_sync.sv
// three-stage pin synchroniser, output moves once stages two and three agree
module iss_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] f1;
        logic [W-1:0] f2;
        logic [W-1:0] f3;
        logic [W-1:0] q;
    } iss_sync_state_t;

    iss_sync_state_t r;
    iss_sync_state_t next_r;

    always_comb begin
        next_r    = r;
        next_r.f1 = d;
        next_r.f2 = r.f1;
        next_r.f3 = r.f2;
        next_r.q  = (r.q & (r.f2 ^ r.f3)) | (r.f3 & ~(r.f2 ^ r.f3));
    end

    // idle bus and select read high, so reset to ones
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '1;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.q;
endmodule : iss_sync

// file: iss_device.sv
// device end: startup, address latch, warm reset, sleep and byte slave
module iss_device #(
    parameter int unsigned READY_CYC  = iss_pkg::D_READY_CYC,
    parameter int unsigned SAMPLE_CYC = iss_pkg::D_SAMPLE_CYC,
    parameter int unsigned SLEEP_CYC  = iss_pkg::D_SLEEP_CYC
) (
    input  wire logic       clk_link,
    input  wire logic       rst_n,
    input  wire logic [7:0] tx_byte,
    output logic            address_low_bit,
    output logic            ready,
    output logic            asleep,
    output logic [7:0]      rx_byte,
    output logic            rx_valid,
    output logic            tx_take,
    iss_link_if.dev         lnk
);
    typedef struct packed {
        iss_pkg::iss_dst_t st;
        logic [19:0]       cnt;
        logic [13:0]       idle;
        logic              sel_lat;
        logic              ready;
        logic              asleep;
        logic              sda_o;
        logic              sda_oe;
        logic [3:0]        bitc;
        logic [7:0]        sh;
        logic [7:0]        rx_byte;
        logic              rx_valid;
        logic              tx_take;
        logic              mack;
        logic              scl_d;
        logic              sda_d;
        logic              sel_d;
    } iss_dev_state_t;

    iss_dev_state_t r;
    iss_dev_state_t next_r;
    logic [2:0]     pins;
    logic           scl;
    logic           sda;
    logic           sel;
    logic           rise;
    logic           fall;
    logic           start;
    logic           stop;

    iss_sync #(.W(3)) u_sync (
        .clk   (clk_link),
        .rst_n (rst_n),
        .d     ({lnk.scl, lnk.sda, lnk.sel}),
        .q     (pins)
    );

    assign scl   = pins[2];
    assign sda   = pins[1];
    assign sel   = pins[0];
    assign rise  = scl && !r.scl_d;
    assign fall  = !scl && r.scl_d;
    assign start = scl && r.scl_d && r.sda_d && !sda;
    assign stop  = scl && r.scl_d && !r.sda_d && sda;

    always_comb begin
        next_r          = r;
        next_r.rx_valid = 1'h0;
        next_r.tx_take  = 1'h0;
        next_r.scl_d    = scl;
        next_r.sda_d    = sda;
        next_r.sel_d    = sel;
        if (r.sel_d && !sel) begin
            next_r.st     = iss_pkg::DS_BOOT;
            next_r.cnt    = '0;
            next_r.ready  = 1'h0;
            next_r.sda_oe = 1'h0;
        end else if (r.st == iss_pkg::DS_BOOT) begin
            next_r.cnt = r.cnt + 20'h0_0001;
            if (r.cnt == 20'(SAMPLE_CYC)) begin
                next_r.sel_lat = sel;
            end
            // bus is not looked at until the interval ends
            if (r.cnt == 20'(READY_CYC)) begin
                next_r.st    = iss_pkg::DS_IDLE;
                next_r.ready = 1'h1;
            end
        end else if (start) begin
            next_r.st     = iss_pkg::DS_ADDR;
            next_r.bitc   = '0;
            next_r.sda_oe = 1'h0;
        end else if (stop) begin
            next_r.st     = iss_pkg::DS_IDLE;
            next_r.sda_oe = 1'h0;
        end else begin
            case (r.st)
                iss_pkg::DS_ADDR, iss_pkg::DS_WR: begin
                    if (rise) begin
                        next_r.sh   = {r.sh[6:0], sda};
                        next_r.bitc = r.bitc + 4'h1;
                    end else if (fall && r.bitc == iss_pkg::ACK_SLOT) begin
                        if (r.st == iss_pkg::DS_WR) begin
                            next_r.st       = iss_pkg::DS_WACK;
                            next_r.sda_oe   = 1'h1;
                            next_r.rx_byte  = r.sh;
                            next_r.rx_valid = 1'h1;
                        end else if (r.sh[7:1] == {iss_pkg::ADDR_HI, r.sel_lat}) begin
                            next_r.st     = iss_pkg::DS_AACK;
                            next_r.sda_oe = 1'h1;
                            next_r.asleep = 1'h0;
                        end else begin
                            next_r.st = iss_pkg::DS_IDLE;
                        end
                    end
                end
                iss_pkg::DS_AACK: begin
                    if (fall) begin
                        next_r.bitc = '0;
                        if (r.sh[0]) begin
                            next_r.st      = iss_pkg::DS_RD;
                            next_r.sh      = tx_byte;
                            next_r.tx_take = 1'h1;
                            next_r.sda_oe  = !tx_byte[7];
                        end else begin
                            next_r.st     = iss_pkg::DS_WR;
                            next_r.sda_oe = 1'h0;
                        end
                    end
                end
                iss_pkg::DS_WACK: begin
                    if (fall) begin
                        next_r.st     = iss_pkg::DS_WR;
                        next_r.bitc   = '0;
                        next_r.sda_oe = 1'h0;
                    end
                end
                iss_pkg::DS_RD: begin
                    if (fall) begin
                        if (r.bitc == iss_pkg::LAST_BIT) begin
                            next_r.st     = iss_pkg::DS_RACK;
                            next_r.sda_oe = 1'h0;
                        end else begin
                            next_r.sh     = {r.sh[6:0], 1'h0};
                            next_r.sda_oe = !r.sh[6];
                            next_r.bitc   = r.bitc + 4'h1;
                        end
                    end
                end
                iss_pkg::DS_RACK: begin
                    if (rise) begin
                        next_r.mack = sda;
                    end else if (fall) begin
                        // a master nack ends the read; wait for stop
                        if (!r.mack) begin
                            next_r.st      = iss_pkg::DS_RD;
                            next_r.bitc    = '0;
                            next_r.sh      = tx_byte;
                            next_r.tx_take = 1'h1;
                            next_r.sda_oe  = !tx_byte[7];
                        end else begin
                            next_r.st = iss_pkg::DS_IDLE;
                        end
                    end
                end
                default: begin
                    next_r.sda_oe = 1'h0;
                end
            endcase
        end
        // sleep is entered only by this idle timer
        if (next_r.st == iss_pkg::DS_IDLE && r.st == iss_pkg::DS_IDLE) begin
            if (!r.asleep) begin
                next_r.idle = r.idle + 14'h0001;
            end
            if (r.idle == 14'(SLEEP_CYC)) begin
                next_r.asleep = 1'h1;
            end
        end else begin
            next_r.idle = '0;
        end
    end

    always_ff @(posedge clk_link or negedge rst_n) begin
        if (!rst_n) begin
            r       <= '0;
            r.st    <= iss_pkg::DS_BOOT;
            r.scl_d <= 1'h1;
            r.sda_d <= 1'h1;
            r.sel_d <= 1'h1;
        end else begin
            r <= next_r;
        end
    end

    assign lnk.d_sda_o     = r.sda_o;
    assign lnk.d_sda_oe    = r.sda_oe;
    assign address_low_bit = r.sel_lat;
    assign ready           = r.ready;
    assign asleep          = r.asleep;
    assign rx_byte         = r.rx_byte;
    assign rx_valid        = r.rx_valid;
    assign tx_take         = r.tx_take;
endmodule : iss_device

// file: iss_host.sv
// host end: power-up and warm-reset sequencing plus one-byte bus master
module iss_host #(
    parameter int unsigned STARTUP_CYC = iss_pkg::H_STARTUP_CYC,
    parameter int unsigned HRST_CYC    = iss_pkg::H_HRST_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       addr_level,
    input  wire logic       hold_sel,
    input  wire logic       warm_req,
    input  wire logic       xfer_req,
    input  wire logic       xfer_rw,
    input  wire logic [7:0] xfer_wdata,
    output logic            ready,
    output logic            busy,
    output logic            done,
    output logic            ack_ok,
    output logic            warm_ok,
    output logic [7:0]      rdata,
    iss_link_if.host        lnk
);
    localparam logic [5:0] QLAST = 6'(iss_pkg::H_QUARTER_CYC - 1);
    localparam logic [17:0] BOOT_LAST = 18'(STARTUP_CYC - 1);
    localparam logic [17:0] LOW_CYC = 18'(iss_pkg::H_RSTLOW_CYC);
    localparam logic [14:0] HRST_LAST = 15'(HRST_CYC - 1);

    typedef struct packed {
        iss_pkg::iss_hst_t st;
        logic [17:0]       cnt;
        logic [14:0]       hcnt;
        logic [5:0]        q;
        logic [1:0]        ph;
        logic [3:0]        bi;
        logic              by;
        logic              rw;
        logic              nack;
        logic              level;
        logic              warm;
        logic              started;
        logic              warm_ok;
        logic [7:0]        sh;
        logic [7:0]        wd;
        logic [7:0]        rd;
        logic [7:0]        rdata;
        logic              done;
        logic              ack_ok;
        logic              ready;
        logic              busy;
        logic              scl_oe;
        logic              sda_oe;
        logic              sel_o;
        logic              sel_oe;
    } iss_host_state_t;

    iss_host_state_t r;
    iss_host_state_t next_r;
    logic            sda;
    logic            tick;
    logic            drv;

    iss_sync #(.W(1)) u_sync (
        .clk   (clk_sys),
        .rst_n (rst_n),
        .d     (lnk.sda),
        .q     (sda)
    );

    assign tick = (r.q == QLAST);
    // the data byte of a read is driven by the device, not by us
    assign drv  = !(r.by && r.rw);

    always_comb begin
        next_r      = r;
        next_r.done = 1'h0;
        if (r.started && !r.warm_ok) begin
            next_r.hcnt = r.hcnt + 15'h0001;
            if (r.hcnt == HRST_LAST) begin
                next_r.warm_ok = !hold_sel;
            end
        end
        if (r.st == iss_pkg::HS_START || r.st == iss_pkg::HS_BIT || r.st == iss_pkg::HS_STOP) begin
            next_r.q = tick ? 6'h00 : r.q + 6'h01;
        end
        case (r.st)
            iss_pkg::HS_CAPT: begin
                // strap level is caught on the first edge after release
                next_r.level  = addr_level;
                next_r.sel_o  = addr_level;
                next_r.sel_oe = 1'h1;
                next_r.cnt    = '0;
                next_r.st     = iss_pkg::HS_BOOT;
            end
            iss_pkg::HS_BOOT: begin
                next_r.cnt = r.cnt + 18'h0_0001;
                if (r.warm && r.cnt < LOW_CYC) begin
                    next_r.sel_o = 1'h0;
                end else begin
                    next_r.sel_o = r.level;
                end
                if (r.cnt == BOOT_LAST) begin
                    next_r.st    = iss_pkg::HS_IDLE;
                    next_r.ready = 1'h1;
                    // a strapped low select is never raised
                    if (!hold_sel) begin
                        next_r.sel_o = 1'h1;
                    end
                end
            end
            iss_pkg::HS_IDLE: begin
                if (xfer_req) begin
                    next_r.st      = iss_pkg::HS_START;
                    next_r.q       = '0;
                    next_r.ph      = '0;
                    next_r.busy    = 1'h1;
                    next_r.started = 1'h1;
                    next_r.nack    = 1'h0;
                    next_r.rw      = xfer_rw;
                    next_r.wd      = xfer_wdata;
                    next_r.sh      = {iss_pkg::ADDR_HI, r.level, xfer_rw};
                end else if (warm_req && r.warm_ok && !hold_sel) begin
                    // bus is already released here, so both lines read high
                    next_r.st      = iss_pkg::HS_BOOT;
                    next_r.warm    = 1'h1;
                    next_r.cnt     = '0;
                    next_r.ready   = 1'h0;
                    next_r.sel_o   = 1'h0;
                    next_r.warm_ok = 1'h0;
                    next_r.started = 1'h0;
                    next_r.hcnt    = '0;
                end
            end
            iss_pkg::HS_START: begin
                if (tick) begin
                    if (r.ph == 2'h0) begin
                        next_r.sda_oe = 1'h1;
                        next_r.ph     = 2'h1;
                    end else begin
                        next_r.st     = iss_pkg::HS_BIT;
                        next_r.ph     = 2'h0;
                        next_r.bi     = '0;
                        next_r.by     = 1'h0;
                        next_r.scl_oe = 1'h1;
                        next_r.sda_oe = !r.sh[7];
                    end
                end
            end
            iss_pkg::HS_BIT: begin
                if (tick) begin
                    next_r.ph = r.ph + 2'h1;
                    case (r.ph)
                        2'h0: begin
                            next_r.scl_oe = 1'h0;
                        end
                        2'h1: begin
                            if (r.bi == iss_pkg::ACK_SLOT) begin
                                if (drv) begin
                                    next_r.nack = sda;
                                end
                            end else if (!drv) begin
                                next_r.rd = {r.rd[6:0], sda};
                            end
                        end
                        2'h2: begin
                            next_r.scl_oe = 1'h1;
                        end
                        default: begin
                            if (r.bi != iss_pkg::ACK_SLOT) begin
                                next_r.bi     = r.bi + 4'h1;
                                next_r.sh     = {r.sh[6:0], 1'h0};
                                next_r.sda_oe = (r.bi != iss_pkg::LAST_BIT) && drv && !r.sh[6];
                            end else if (!r.by && !r.nack) begin
                                next_r.by     = 1'h1;
                                next_r.bi     = '0;
                                next_r.sh     = r.wd;
                                next_r.sda_oe = !r.rw && !r.wd[7];
                            end else begin
                                next_r.st     = iss_pkg::HS_STOP;
                                next_r.ph     = 2'h0;
                                next_r.sda_oe = 1'h1;
                            end
                        end
                    endcase
                end
            end
            iss_pkg::HS_STOP: begin
                if (tick) begin
                    next_r.ph = r.ph + 2'h1;
                    if (r.ph == 2'h0) begin
                        next_r.scl_oe = 1'h0;
                    end else if (r.ph == 2'h1) begin
                        next_r.sda_oe = 1'h0;
                    end else begin
                        next_r.st     = iss_pkg::HS_IDLE;
                        next_r.busy   = 1'h0;
                        next_r.done   = 1'h1;
                        next_r.ack_ok = !r.nack;
                        next_r.rdata  = r.rd;
                    end
                end
            end
            default: begin
                next_r.st = iss_pkg::HS_CAPT;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r    <= '0;
            r.st <= iss_pkg::HS_CAPT;
        end else begin
            r <= next_r;
        end
    end

    assign lnk.h_scl_o  = 1'h0;
    assign lnk.h_scl_oe = r.scl_oe;
    assign lnk.h_sda_o  = 1'h0;
    assign lnk.h_sda_oe = r.sda_oe;
    assign lnk.h_sel_o  = r.sel_o;
    assign lnk.h_sel_oe = r.sel_oe;
    assign ready        = r.ready;
    assign busy         = r.busy;
    assign done         = r.done;
    assign ack_ok       = r.ack_ok;
    assign warm_ok      = r.warm_ok;
    assign rdata        = r.rdata;
endmodule : iss_host

// file: iss_link_chk.sv
// wire-level assertions for the address-select link
module iss_link_chk #(
    parameter int unsigned STARTUP_CYC = iss_pkg::H_STARTUP_CYC,
    parameter int unsigned READY_CYC   = iss_pkg::D_READY_CYC
) (
    input  wire logic clk_sys,
    input  wire logic clk_link,
    input  wire logic rst_n,
    input  wire logic h_scl_o,
    input  wire logic h_sda_o,
    input  wire logic d_sda_o,
    input  wire logic d_sda_oe,
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic sel
);
    logic [31:0] low_cnt;
    logic [31:0] since_fall;
    logic [31:0] boot_cnt;
    logic        sel_q;
    logic        sel_lq;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt    <= 32'h0000_0000;
            since_fall <= 32'h0000_0000;
            sel_q      <= 1'b1;
        end else begin
            sel_q      <= sel;
            low_cnt    <= sel ? 32'h0000_0000 : low_cnt + 32'h0000_0001;
            since_fall <= (sel_q && !sel) ? 32'h0000_0000 : since_fall + 32'h0000_0001;
        end
    end

    // raw pin fall is seen before the device synchroniser, so this boot window is conservative
    always_ff @(posedge clk_link or negedge rst_n) begin
        if (!rst_n) begin
            boot_cnt <= 32'h0000_0000;
            sel_lq   <= 1'b1;
        end else begin
            sel_lq   <= sel;
            boot_cnt <= (sel_lq && !sel) ? 32'h0000_0000 : boot_cnt + 32'h0000_0001;
        end
    end

    a_open_drain_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !h_scl_o && !h_sda_o && !d_sda_o) else $error("open-drain line driven high");
    a_dev_scl_low: assert property (@(posedge clk_link) disable iff (!rst_n)
        $changed(d_sda_oe) |-> !scl) else $error("device moved data while clock high");
    a_dev_boot_quiet: assert property (@(posedge clk_link) disable iff (!rst_n)
        boot_cnt < READY_CYC |-> !d_sda_oe) else $error("device drove bus during boot");
    a_dev_drive_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(d_sda_oe) |-> ##[1:1000] !d_sda_oe) else $error("device held data line too long");
    a_warm_bus_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(sel) |-> scl && sda) else $error("select fell with bus busy");
    a_warm_low_width: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(sel) |-> low_cnt >= iss_pkg::H_RSTLOW_CYC - 1) else $error("select low pulse too short");
    a_first_xfer_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(scl) |-> since_fall >= STARTUP_CYC) else $error("transfer began inside startup");
    a_sel_xfer_steady: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !scl |-> $stable(sel)) else $error("select moved during a transfer");
endmodule : iss_link_chk

// file: iss_tb_top.sv
// self-checking bench joining host and device ends over the link
module iss_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys    = 1'b0;
    logic       clk_link   = 1'b0;
    logic       rst_n      = 1'b0;
    logic       addr_level = 1'b0;
    logic       warm_req   = 1'b0;
    logic       hold_sel   = 1'b0;
    logic       xfer_req   = 1'b0;
    logic       xfer_rw    = 1'b0;
    logic [7:0] xfer_wdata = 8'h00;
    logic [7:0] tx_byte    = 8'h00;
    logic [7:0] rx_seen    = 8'h00;
    logic       h_ready, busy, done, ack_ok, warm_ok, d_ready, asleep, rx_valid, addr_bit;
    logic [7:0] rdata, rx_byte;
    int         error_cnt  = 0;
    int         n_checks   = 0;
    int         cyc        = 0;

    iss_link_if lnk ();
    always #25 clk_sys = !clk_sys;
    initial begin
        #3.3;
        forever #6 clk_link = !clk_link;
    end

    // device ready at 18 us stays ahead of host startup at 20 us; sample lands after the 10 us low
    // warm-reset hold-off and sleep timer keep their real lengths so their edges are exercised
    iss_host #(.STARTUP_CYC(400)) iss_host_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .addr_level(addr_level), .hold_sel(hold_sel), .warm_req(warm_req), .xfer_req(xfer_req),
        .xfer_rw(xfer_rw), .xfer_wdata(xfer_wdata), .ready(h_ready), .busy(busy), .done(done),
        .ack_ok(ack_ok), .warm_ok(warm_ok), .rdata(rdata), .lnk(lnk));
    iss_device #(.READY_CYC(1500), .SAMPLE_CYC(1000)) iss_device_inst (
        .clk_link(clk_link), .rst_n(rst_n), .tx_byte(tx_byte), .address_low_bit(addr_bit),
        .ready(d_ready), .asleep(asleep), .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_take(), .lnk(lnk));
    iss_link_chk #(.STARTUP_CYC(400), .READY_CYC(1500)) iss_link_chk_inst (.clk_sys(clk_sys),
        .clk_link(clk_link), .rst_n(rst_n), .h_scl_o(lnk.h_scl_o), .h_sda_o(lnk.h_sda_o),
        .d_sda_o(lnk.d_sda_o), .d_sda_oe(lnk.d_sda_oe), .scl(lnk.scl), .sda(lnk.sda), .sel(lnk.sel));

    always @(posedge clk_link) begin
        if (rx_valid === 1'b1) begin
            rx_seen <= rx_byte;
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic wait_ready();
        int n;
        n = 0;
        while (h_ready !== 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
        chk({7'h00, h_ready}, 8'h01);
        chk({7'h00, d_ready}, 8'h01);
    endtask : wait_ready

    // one address byte plus one data byte; the bus needs about 77 quarters of 50 cycles
    task automatic xfer(input logic rw, input logic [7:0] wd);
        int n;
        @(posedge clk_sys);
        xfer_rw    <= rw;
        xfer_wdata <= wd;
        xfer_req   <= 1'b1;
        @(posedge clk_sys);
        xfer_req   <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 10000) begin
            tick(1);
            n++;
        end
        chk({7'h00, done}, 8'h01);
        chk({7'h00, ack_ok}, 8'h01);
    endtask : xfer

    task automatic warm_pulse(input logic hs);
        @(posedge clk_sys);
        hold_sel <= hs;
        warm_req <= 1'b1;
        @(posedge clk_sys);
        warm_req <= 1'b0;
        tick(10);
    endtask : warm_pulse

    initial begin
        tick(20);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        wait_ready();
        chk({7'h00, addr_bit}, 8'h00);
        tx_byte <= 8'hc3;
        xfer(1'b0, 8'h5a);
        chk(rx_seen, 8'h5a);
        xfer(1'b1, 8'h00);
        chk(rdata, 8'hc3);
        $display("test low address done");
        tick(2100);
        chk({7'h00, asleep}, 8'h01);
        xfer(1'b0, 8'ha5);
        chk(rx_seen, 8'ha5);
        chk({7'h00, asleep}, 8'h00);
        $display("test sleep wake done");
        @(posedge clk_sys);
        rst_n      <= 1'b0;
        addr_level <= 1'b1;
        tick(20);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        wait_ready();
        chk({7'h00, addr_bit}, 8'h01);
        xfer(1'b0, 8'h96);
        chk(rx_seen, 8'h96);
        chk({7'h00, warm_ok}, 8'h00);
        tick(16300);
        chk({7'h00, warm_ok}, 8'h01);
        warm_pulse(1'b1);
        chk({7'h00, h_ready}, 8'h01);
        warm_pulse(1'b0);
        chk({7'h00, d_ready}, 8'h00);
        wait_ready();
        chk({7'h00, addr_bit}, 8'h01);
        xfer(1'b0, 8'h3c);
        chk(rx_seen, 8'h3c);
        $display("test warm reset done");
        test_done();
    end
endmodule : iss_tb_top
